/* core/pwm8_top.v */
// 8-bit pulse width modulator with APB registers and interrupt
`timescale 1ns/1ps
`include "pwm8_regs.vh"
module pwm8_top (
  input wire pclk,
  input wire presetn,
  input wire [19:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire external_clock_input,
  output reg pulse_out,
  output reg irq
);

  // Control fields
  reg run_reg;
  reg run_next;
  reg clr_reg;
  reg clr_next;
  reg size7_reg;
  reg size7_next;
  reg halve_reg;
  reg halve_next;

  // Pulse width value
  reg [7:0] width_reg;
  reg [7:0] width_next;

  // Counter
  reg [7:0] count_reg;
  reg [7:0] count_next;

  // Interrupt state
  reg [`PWM_EVT_W-1:0] status_reg;
  reg [`PWM_EVT_W-1:0] status_next;
  reg [`PWM_EVT_W-1:0] mask_reg;
  reg [`PWM_EVT_W-1:0] mask_next;
  reg [`PWM_EVT_W-1:0] evt;
  reg [`PWM_EVT_W-1:0] w1c;

  // Output next values
  reg pulse_next;
  reg irq_next;
  reg [31:0] rdata_next;
  reg map_hit;

  // Bus decode
  wire [17:0] word_idx;
  wire setup;
  wire wr_take;
  wire wr_ctrl;
  wire wr_width;
  wire wr_stat;
  wire wr_mask;

  // Counter helpers
  wire tick;
  wire [7:0] top;
  wire at_top;
  wire [7:0] count_adv;
  wire step;
  reg [7:0] ctrl_view;

  // Word index; the two low address bits are ignored
  assign word_idx = paddr[19:2];
  assign setup = psel & ~penable;
  assign wr_take = psel & penable & pready & pwrite & ~pslverr;
  // Write strobes fire on the access edge only
  assign wr_ctrl = wr_take & (word_idx == `PWM_IDX_CTRL);
  assign wr_width = wr_take & (word_idx == `PWM_IDX_WIDTH);
  assign wr_stat = wr_take & (word_idx == `PWM_IDX_STAT);
  assign wr_mask = wr_take & (word_idx == `PWM_IDX_MASK);

  // Tick enable from the synchronised external clock input
  pwm8_clk_div u_div (
    .pclk(pclk),
    .presetn(presetn),
    .ext_clk_pin(external_clock_input),
    .halve(halve_reg),
    .restart(clr_reg),
    .tick_reg(tick)
  );

  // Wrap on >= so a count left above the seven-bit top still wraps
  assign top = size7_reg ? `PWM_TOP7 : `PWM_TOP8; // R2
  assign at_top = (count_reg >= top); // R2
  assign count_adv = at_top ? `PWM_COUNT_RST : count_reg + 8'h01; // R2
  // Clear takes priority over a tick in the same clock
  assign step = run_reg & tick & ~clr_reg; // R1 R4

  // Control readback; the clear bit reads one for its single clock
  always @* begin
    ctrl_view = `PWM_CTRL_RST;
    ctrl_view[`PWM_CTRL_RUN] = run_reg;
    ctrl_view[`PWM_CTRL_CLR] = clr_reg;
    ctrl_view[`PWM_CTRL_SIZE7] = size7_reg;
    ctrl_view[`PWM_CTRL_HALVE] = halve_reg;
  end

  // Control register next values
  always @* begin
    run_next = run_reg;
    size7_next = size7_reg;
    halve_next = halve_reg;
    clr_next = 1'b0; // R5
    if (wr_ctrl) begin
      run_next = pwdata[`PWM_CTRL_RUN]; // R4
      size7_next = pwdata[`PWM_CTRL_SIZE7]; // R2
      halve_next = pwdata[`PWM_CTRL_HALVE]; // R3
      clr_next = pwdata[`PWM_CTRL_CLR]; // R5
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_reg <= 1'b0;
      size7_reg <= 1'b0;
      halve_reg <= 1'b0;
    end else begin
      run_reg <= run_next;
      size7_reg <= size7_next;
      halve_reg <= halve_next;
    end
  end

  // Clear bit lives one clock; it also restarts the divider phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clr_reg <= 1'b0;
    end else begin
      clr_reg <= clr_next; // R5
    end
  end

  // Pulse width value register
  always @* begin
    width_next = width_reg;
    if (wr_width) begin
      width_next = pwdata[7:0]; // R10
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      width_reg <= `PWM_WIDTH_RST;
    end else begin
      width_reg <= width_next;
    end
  end

  // Up counter: clear wins, then step, otherwise hold
  always @* begin
    count_next = count_reg; // R1
    if (clr_reg) begin
      count_next = `PWM_COUNT_RST; // R5
    end else if (step) begin
      count_next = count_adv;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= `PWM_COUNT_RST; // R12
    end else begin
      count_reg <= count_next;
    end
  end

  // Events raised on counter steps
  always @* begin
    evt = `PWM_EVT_RST;
    evt[`PWM_EVT_OVF] = step & at_top; // R8
    // Match looks at the value the counter steps onto
    evt[`PWM_EVT_MATCH] = step & (count_adv == width_reg); // R7
  end

  // Pulse output; the top count is always low
  always @* begin
    pulse_next = 1'b0; // R12
    if (run_reg) begin
      pulse_next = (count_next < width_reg) & (count_next != top); // R6 R11
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_out <= 1'b0; // R12
    end else begin
      pulse_out <= pulse_next;
    end
  end

  // Sticky status, write one to clear, set wins over clear
  always @* begin
    w1c = `PWM_EVT_RST;
    if (wr_stat) begin
      w1c = pwdata[`PWM_EVT_W-1:0];
    end
    status_next = (status_reg & ~w1c) | evt;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= `PWM_EVT_RST;
    end else begin
      status_reg <= status_next; // R7 R8
    end
  end

  // Interrupt mask, same layout as the status
  always @* begin
    mask_next = mask_reg;
    if (wr_mask) begin
      mask_next = pwdata[`PWM_EVT_W-1:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= `PWM_EVT_RST;
    end else begin
      mask_reg <= mask_next;
    end
  end

  // Level interrupt; built from next values so it lines up with status
  always @* begin
    irq_next = |(status_next & mask_next);
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_next;
    end
  end

  // Read data and address check, sampled in the setup cycle
  always @* begin
    rdata_next = 32'h00000000;
    map_hit = 1'b1;
    case (word_idx)
      `PWM_IDX_CTRL: begin
        rdata_next[7:0] = ctrl_view;
      end
      `PWM_IDX_WIDTH: begin
        rdata_next[7:0] = width_reg;
      end
      `PWM_IDX_STAT: begin
        rdata_next[`PWM_EVT_W-1:0] = status_reg;
      end
      `PWM_IDX_MASK: begin
        rdata_next[`PWM_EVT_W-1:0] = mask_reg;
      end
      `PWM_IDX_COUNT: begin
        rdata_next[7:0] = count_reg;
      end
      default: begin
        map_hit = 1'b0;
      end
    endcase
  end

  // One access cycle: ready is high in every access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  // Error answer only for an index outside the map
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= ~map_hit;
    end else begin
      pslverr <= 1'b0;
    end
  end

  // Read data captured at the setup edge; writes and misses read zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup) begin
      if (pwrite | ~map_hit) begin
        prdata <= 32'h00000000;
      end else begin
        prdata <= rdata_next;
      end
    end
  end

endmodule // pwm8_top

/* shared/pwm8_regs.vh */
// Register map, field positions and reset values of the 8-bit pulse modulator
// What this block does
// R1 - Clearing run enable freezes the count; setting it again resumes there.
// R2 - Control bit 2 picks period: 0 gives 256 counts, 1 gives 127.
// R3 - Counter ticks come from the external clock, halved when bit 4 is set.
// R4 - Control bit 0 is run enable: one counts and pulses, zero stops.
// R5 - Writing one to control bit 1 clears the counter; bit self-clears next clock.
// R6 - Output is high from count zero up to width value, then low.
// R7 - Match event when counter equals the pulse width value.
// R8 - Overflow event when counter rolls from its top back to zero.
// R9 - Software sets period, divider, width, clears counter, then sets run.
// R10 - Eight-bit width register, range 0-255 or 0-126 by period.
// R11 - Every period holds at least one low clock, whatever the width.
// R12 - After reset count is zero and output low until run is set.
`ifndef PWM8_REGS_VH
`define PWM8_REGS_VH

// Register indices; byte address is four times the index
`define PWM_IDX_CTRL 18'h06003
`define PWM_IDX_WIDTH 18'h06007
`define PWM_IDX_STAT 18'h06008
`define PWM_IDX_MASK 18'h06009
`define PWM_IDX_COUNT 18'h0600A

// Control register fields
`define PWM_CTRL_RUN 0
`define PWM_CTRL_CLR 1
`define PWM_CTRL_SIZE7 2
`define PWM_CTRL_HALVE 4

// Interrupt status and mask fields
`define PWM_EVT_MATCH 0
`define PWM_EVT_OVF 1
`define PWM_EVT_W 2

// Reset values
`define PWM_CTRL_RST 8'h00
`define PWM_WIDTH_RST 8'h00
`define PWM_EVT_RST 2'h0
`define PWM_COUNT_RST 8'h00

// Top counts of the two period lengths
`define PWM_TOP8 8'hFF
`define PWM_TOP7 8'h7E

`endif

/* core/pwm8_clk_div.v */
// External clock synchroniser and divide-by-one-or-two tick generator
`timescale 1ns/1ps
module pwm8_clk_div (
  input wire pclk,
  input wire presetn,
  input wire ext_clk_pin,
  input wire halve,
  input wire restart,
  output reg tick_reg
);

  reg sync1_reg;
  reg sync2_reg;
  reg last_reg;
  reg phase_reg;
  wire rise;

  // Two-stage synchroniser, then edge detect on the second stage
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      sync1_reg <= ext_clk_pin;
      sync2_reg <= sync1_reg;
      last_reg <= sync2_reg;
    end
  end

  assign rise = sync2_reg & ~last_reg;

  // Halving drops every second rising edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= 1'b0;
      tick_reg <= 1'b0;
    end else begin
      if (restart) begin
        phase_reg <= 1'b0;
      end else if (rise) begin
        phase_reg <= ~phase_reg;
      end
      tick_reg <= rise & (~halve | phase_reg) & ~restart; // R3
    end
  end

endmodule // pwm8_clk_div

/* verif/pwm8_top_properties.sv */
// Port checks of the pulse modulator
`timescale 1ns/1ps
`include "pwm8_regs.vh"
module pwm8_chk (
  input logic pclk,
  input logic presetn,
  input logic [19:0] paddr,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic external_clock_input,
  input logic pulse_out,
  input logic irq
);
  localparam [19:0] adr_c = {`PWM_IDX_CTRL, 2'b00};
  localparam [19:0] adr_n = {`PWM_IDX_COUNT, 2'b00};
  logic [3:0] gap_reg;
  wire acc = psel && penable && pready;
  wire rd = acc && !pwrite;
  // Cycles since a clock input rise or a register write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_reg <= 4'hF;
    end else begin
      gap_reg <= ($rose(external_clock_input) || (acc && pwrite)) ? 4'h0 :
        gap_reg + {3'h0, gap_reg != 4'hF};
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rst; $rose(presetn) |-> !pulse_out && !irq; endproperty
  a_rst: assert property (p_rst) else $error("active at reset");
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("long ready");
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("bad error");
  property p_ctl; rd && paddr == adr_c |-> prdata[31:5] == 27'h0 &&
    !prdata[3]; endproperty
  a_ctl: assert property (p_ctl) else $error("control bits");
  property p_cnt; rd && paddr == adr_n |-> prdata[31:8] == 24'h0; endproperty
  a_cnt: assert property (p_cnt) else $error("count bits");
  property p_chg; $changed(pulse_out) |-> gap_reg < 4'hA; endproperty
  a_chg: assert property (p_chg) else $error("stray pulse");
  property p_irq; $rose(irq) |-> gap_reg < 4'hA; endproperty
  a_irq: assert property (p_irq) else $error("stray irq");
  c_err: cover property (pslverr);
  c_irq: cover property ($rose(irq));
  c_fall: cover property ($fell(pulse_out));
endmodule // pwm8_chk
bind pwm8_top pwm8_chk u_pwm8_chk (
  .pclk(pclk),
  .presetn(presetn),
  .paddr(paddr),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .external_clock_input(external_clock_input),
  .pulse_out(pulse_out),
  .irq(irq)
);

/* verif/pwm8_ext.sv */
// Clock source and load on the pulse pin
`timescale 1ns/1ps
module pwm8_ext (
  input logic slow,
  input logic pulse_out,
  output logic ext_clk,
  output int hi_last
);
  int run_n = 0;
  initial begin
    ext_clk = 1'b0;
    forever #(slow ? 40 : 24) ext_clk = ~ext_clk;
  end
  // Source rises seen while the pin is high
  always @(posedge ext_clk) begin
    if (pulse_out)
      run_n++;
  end
  always @(negedge pulse_out) begin
    hi_last = run_n;
    run_n = 0;
  end
endmodule // pwm8_ext

/* verif/pwm8_top_tb.sv */
// Self-checking bench of the pulse modulator
`timescale 1ns/1ps
`include "pwm8_regs.vh"
module pwm8_top_tb;
  localparam [19:0] a_ctl = {`PWM_IDX_CTRL, 2'b00};
  localparam [19:0] a_wid = {`PWM_IDX_WIDTH, 2'b00};
  localparam [19:0] a_sta = {`PWM_IDX_STAT, 2'b00};
  localparam [19:0] a_msk = {`PWM_IDX_MASK, 2'b00};
  localparam [19:0] a_cnt = {`PWM_IDX_COUNT, 2'b00};
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0;
  logic [19:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] prdata, rd_v, held;
  logic pready, pslverr, rd_e, external_clock_input, pulse_out, irq;
  int n_fail = 0, n_compared = 0, hi_n;
  pwm8_top u_pwm8_top (
    .pclk(pclk),
    .presetn(presetn),
    .paddr(paddr),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .external_clock_input(external_clock_input),
    .pulse_out(pulse_out),
    .irq(irq)
  );
  pwm8_ext u_pwm8_ext (.slow(slow), .pulse_out(pulse_out),
    .ext_clk(external_clock_input), .hi_last(hi_n));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %h not %h", $time, seen, exp);
    end
  endtask
  task xfer(input logic w, input logic [19:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_v = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [19:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd_v, exp);
  endtask
  task t_regs;
    rd(a_ctl, 32'h0);
    rd(a_cnt, 32'h0);
    rd(a_wid, 32'h0);
    chk(pulse_out, 1'b0);
    xfer(1'b1, a_wid, 32'hFFFFFFA5);
    rd(a_wid, 32'hA5);
    xfer(1'b1, a_ctl, 32'hFE);
    rd(a_ctl, 32'h14);
    xfer(1'b1, a_cnt, 32'h55);
    rd(a_cnt, 32'h0);
    rd(20'h0, 32'h0);
    chk(rd_e, 1'b1);
  endtask
  task t_pwm;
    xfer(1'b1, a_msk, 32'h3);
    xfer(1'b1, a_wid, 32'h2);
    xfer(1'b1, a_ctl, 32'h2);
    xfer(1'b1, a_ctl, 32'h1);
    @(posedge irq);
    rd(a_sta, 32'h1);
    @(negedge pulse_out);
    #1;
    chk(hi_n, 32'h2);
    rd(a_sta, 32'h3);
    xfer(1'b1, a_sta, 32'h3);
    rd(a_msk, 32'h3);
    chk(irq, 1'b0);
  endtask
  task t_hold;
    xfer(1'b1, a_ctl, 32'h0);
    xfer(1'b0, a_cnt, 32'h0);
    held = rd_v;
    repeat (40) @(posedge pclk);
    rd(a_cnt, held);
    chk(pulse_out, 1'b0);
    xfer(1'b1, a_ctl, 32'h1);
    repeat (40) @(posedge pclk);
    xfer(1'b0, a_cnt, 32'h0);
    chk(rd_v - held < 32'h9 && rd_v != held, 1'b1);
    xfer(1'b1, a_ctl, 32'h2);
    @(posedge pclk);
    rd(a_cnt, 32'h0);
  endtask
  task t_seven;
    slow <= 1'b1;
    xfer(1'b1, a_wid, 32'hFF);
    xfer(1'b1, a_ctl, 32'h16);
    xfer(1'b1, a_ctl, 32'h15);
    @(negedge pulse_out);
    @(negedge pulse_out);
    #1;
    chk(hi_n, 32'hFC);
    rd(a_ctl, 32'h15);
  endtask
  task give_verdict;
    if (n_fail == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial forever #4 pclk = ~pclk;
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_pwm;
    t_hold;
    t_seven;
    give_verdict;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    give_verdict;
  end
endmodule // pwm8_top_tb
